// ---- rtl/lict_params.svh ----
// constants of the lan interrupt cause and throttle block
// assumes 16-bit byte addresses on a 32-bit register port, 200 MHz mclk
`ifndef LICT_PARAMS_SVH
`define LICT_PARAMS_SVH

`define LICT_ADDR_W        16
`define LICT_DATA_W        32
`define LICT_OFS_CAUSE     16'h00C0
`define LICT_OFS_PACE      16'h00C4
`define LICT_OFS_FORCE     16'h00C8
`define LICT_OFS_ENSET     16'h00D0
`define LICT_OFS_ENCLR     16'h00D8
`define LICT_OFS_AUTOM     16'h00E0

`define LICT_CAUSE_W       23
`define LICT_CAUSE_WMASK   23'h47D2F7
`define LICT_SRC_MASK      23'h05D2F7
`define LICT_BIT_ACK       17
`define LICT_BIT_ECC       22
`define LICT_BIT_ASSERTED  31
`define LICT_RSV_LO        23
`define LICT_RSV_HI        30
`define LICT_PACE_W        16
`define LICT_ACK_W         8
`define LICT_TICK_W        8

`define LICT_RST_CAUSE     23'h000000
`define LICT_RST_MASK      23'h000000
`define LICT_RST_AUTOM     23'h000000
`define LICT_RST_PACE      16'h0000
`define LICT_RST_ACK       8'h00
`define LICT_RST_RDATA     32'h00000000

`define LICT_UNIT_NS       256
`define LICT_CLK_NS        5
`define LICT_UNIT_CYCLES   ((`LICT_UNIT_NS + `LICT_CLK_NS - 1) / `LICT_CLK_NS)
`define LICT_SLOW_FACTOR   4

`endif

// ---- rtl/lict_pkg.sv ----
// types shared by the lan interrupt cause and throttle block
// assumes lict_params.svh is on the include path
`include "lict_params.svh"

package lict_pkg;

   typedef logic [`LICT_CAUSE_W-1:0] lict_cause_t;
   typedef logic [`LICT_PACE_W-1:0]  lict_pace_t;
   typedef logic [`LICT_ACK_W-1:0]   lict_ack_t;
   typedef logic [`LICT_DATA_W-1:0]  lict_data_t;

   typedef struct packed {
      logic [`LICT_ADDR_W-1:0] addr;
      lict_data_t              wdata;
      logic                    wr;
      logic                    rd;
   } lict_bus_s;

   typedef enum logic {
      LICT_THR_IDLE,
      LICT_THR_RUN
   } lict_thr_e;

   typedef struct packed {
      lict_cause_t cause;
      lict_cause_t mask;
      lict_cause_t auto_mask;
      lict_pace_t  pace;
      logic        asserted;
      lict_thr_e   thr;
      lict_pace_t  thr_cnt;
      logic        ack_busy;
      lict_ack_t   ack_cnt;
      lict_data_t  rdata;
      logic        tclr;
   } lict_state_s;

   typedef struct packed {
      logic [`LICT_TICK_W-1:0] cnt;
   } lict_tick_s;

endpackage

// ---- rtl/lict_tick_gen.sv ----
// 256 ns unit tick, four units at slow speed, for the pacing and ack delay timers
// assumes slow_speed is a level synchronous to mclk
`timescale 1ns/1ps
`include "lict_params.svh"

module lict_tick_gen (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic restart,
   input  wire logic slow_speed,
   output logic      tick
);
   import lict_pkg::*;

   localparam logic [`LICT_TICK_W-1:0] FAST_LIM =
      `LICT_TICK_W'(`LICT_UNIT_CYCLES - 1);
   localparam logic [`LICT_TICK_W-1:0] SLOW_LIM =
      `LICT_TICK_W'(`LICT_UNIT_CYCLES * `LICT_SLOW_FACTOR - 1);

   lict_tick_s              s;
   lict_tick_s              n;
   logic [`LICT_TICK_W-1:0] lim;

   // unit rounded up to whole cycles, so spacing never falls short
   assign lim  = slow_speed ? SLOW_LIM : FAST_LIM;
   assign tick = (s.cnt >= lim);

   always_comb begin
      n = s;
      if (restart) begin
         n.cnt = '0;
      end else if (s.cnt >= lim) begin
         n.cnt = '0;
      end else begin
         n.cnt = s.cnt + `LICT_TICK_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s.cnt <= '0;
      end else begin
         s <= n;
      end
   end

endmodule

// ---- rtl/lict_top.sv ----
// interrupt cause latch, cause force, enable mask and pacing timer
// assumes a single-cycle strobe register port and pulse event sources
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "lict_params.svh"

module lict_top (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire lict_pkg::lict_bus_s  bus,
   output lict_pkg::lict_data_t      rdata,
   input  wire lict_pkg::lict_cause_t src_events,
   input  wire logic                 ecc_uncorrectable,
   input  wire logic                 ack_frame_rx,
   input  wire lict_pkg::lict_ack_t  ack_delay,
   input  wire logic                 slow_speed,
   input  wire logic                 pci_int_en,
   output logic                      host_irq,
   output logic                      timers_clear
);
   import lict_pkg::*;

   lict_state_s s;
   lict_state_s n;
   lict_cause_t ev;
   lict_cause_t clr;
   lict_cause_t frc;
   logic        pending;
   logic        fire;
   logic        ack_fire;
   logic        tick;
   logic        ev_any;

   lict_tick_gen u_tick (
      .mclk       (mclk),
      .rst        (rst),
      .restart    (fire),
      .slow_speed (slow_speed),
      .tick       (tick)
   );

   assign rdata        = s.rdata;
   assign timers_clear = s.tclr;
   assign host_irq     = s.asserted & pci_int_en;
   assign ev_any       = |(ev | frc);

   always_comb begin
      n        = s;
      ev       = '0;
      clr      = '0;
      frc      = '0;
      fire     = 1'b0;
      pending  = 1'b0;
      n.rdata  = `LICT_RST_RDATA;
      n.tclr   = 1'b0;
      ack_fire = s.ack_busy && (s.ack_cnt == '0);

      // hardware event sources; ecc comes on its own pin, ack from the ack delay timer
      ev = src_events & `LICT_SRC_MASK;
      ev[`LICT_BIT_ECC] = ecc_uncorrectable;
      ev[`LICT_BIT_ACK] = ack_fire;

      // ack delay counts whole units, so it may run up to one unit short
      if (ack_frame_rx) begin
         n.ack_busy = 1'b1;
         n.ack_cnt  = ack_delay;
      end else if (ack_fire) begin
         n.ack_busy = 1'b0;
      end else if (s.ack_busy && tick) begin
         n.ack_cnt = s.ack_cnt - `LICT_ACK_W'(1);
      end

      if (bus.wr) begin
         if (bus.addr == `LICT_OFS_CAUSE) begin
            // bit 31 is the registered pending flag and not in clr, so writing it has no effect
            clr = bus.wdata[`LICT_CAUSE_W-1:0];
         end else if (bus.addr == `LICT_OFS_PACE) begin
            n.pace = bus.wdata[`LICT_PACE_W-1:0];
         end else if (bus.addr == `LICT_OFS_FORCE) begin
            frc = bus.wdata[`LICT_CAUSE_W-1:0] & `LICT_CAUSE_WMASK;
         end else if (bus.addr == `LICT_OFS_ENSET) begin
            n.mask = s.mask
                   | (bus.wdata[`LICT_CAUSE_W-1:0] & `LICT_CAUSE_WMASK);
         end else if (bus.addr == `LICT_OFS_ENCLR) begin
            n.mask = s.mask & ~bus.wdata[`LICT_CAUSE_W-1:0];
         end else if (bus.addr == `LICT_OFS_AUTOM) begin
            n.auto_mask = bus.wdata[`LICT_CAUSE_W-1:0]
                        & `LICT_CAUSE_WMASK;
         end
      end

      if (bus.rd) begin
         if (bus.addr == `LICT_OFS_CAUSE) begin
            n.rdata = {s.asserted, 8'h00, s.cause};
            if (s.mask == '0) begin
               clr = '1;
            end else if (s.asserted) begin
               clr    = '1;
               n.mask = s.mask & ~s.auto_mask;
            end
            // otherwise the read leaves cause and mask alone and only loads rdata
         end else if (bus.addr == `LICT_OFS_PACE) begin
            n.rdata = {16'h0000, s.pace};
         end else if (bus.addr == `LICT_OFS_ENSET) begin
            n.rdata = {9'h000, s.mask};
         end else if (bus.addr == `LICT_OFS_AUTOM) begin
            n.rdata = {9'h000, s.auto_mask};
         end else begin
            n.rdata = `LICT_RST_RDATA;
         end
      end

      // a new event beats a clear in the same cycle
      n.cause = (s.cause & ~clr) | ev | frc;
      n.tclr  = ev_any;

      pending = |(s.cause & s.mask);
      if (pending && !s.asserted &&
          ((s.pace == '0) || (s.thr == LICT_THR_IDLE))) begin
         fire = 1'b1;
      end

      case (s.thr)
         LICT_THR_IDLE: begin
            if (fire && (s.pace != '0)) begin
               n.thr     = LICT_THR_RUN;
               n.thr_cnt = s.pace;
            end
         end
         LICT_THR_RUN: begin
            if (s.pace == '0) begin
               n.thr     = LICT_THR_IDLE;
               n.thr_cnt = '0;
            end else if (tick) begin
               if (s.thr_cnt <= `LICT_PACE_W'(1)) begin
                  n.thr = LICT_THR_IDLE;
               end
               n.thr_cnt = s.thr_cnt - `LICT_PACE_W'(1);
            end
         end
         default: begin
            n.thr = LICT_THR_IDLE;
         end
      endcase

      if (n.cause == '0) begin
         n.asserted = 1'b0;
      end else if (fire) begin
         n.asserted = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s.cause     <= `LICT_RST_CAUSE;
         s.mask      <= `LICT_RST_MASK;
         s.auto_mask <= `LICT_RST_AUTOM;
         s.pace      <= `LICT_RST_PACE;
         s.asserted  <= 1'b0;
         s.thr       <= LICT_THR_IDLE;
         s.thr_cnt   <= `LICT_RST_PACE;
         s.ack_busy  <= 1'b0;
         s.ack_cnt   <= `LICT_RST_ACK;
         s.rdata     <= `LICT_RST_RDATA;
         s.tclr      <= 1'b0;
      end else begin
         s <= n;
      end
   end

   // helper logic for the checks below
   logic        rd_cause;
   logic        wr_cause;
   logic        wr_force;
   logic        wr_enclr;
   logic        seen_fire;
   logic        run_slow;
   lict_pace_t  fire_pace;
   logic [23:0] gap_cnt;

   assign rd_cause = bus.rd && (bus.addr == `LICT_OFS_CAUSE);
   assign wr_cause = bus.wr && (bus.addr == `LICT_OFS_CAUSE);
   assign wr_force = bus.wr && (bus.addr == `LICT_OFS_FORCE);
   assign wr_enclr = bus.wr && (bus.addr == `LICT_OFS_ENCLR);

   always_ff @(posedge mclk) begin
      // spacing counted fire to fire with the interval of the earlier fire
      if (rst) begin
         seen_fire <= 1'b0;
         run_slow  <= 1'b0;
         fire_pace <= `LICT_RST_PACE;
         gap_cnt   <= 24'h000000;
      end else if (fire) begin
         seen_fire <= 1'b1;
         run_slow  <= slow_speed;
         fire_pace <= s.pace;
         gap_cnt   <= 24'h000001;
      end else begin
         run_slow <= run_slow & slow_speed;
         if (gap_cnt != 24'hFFFFFF) begin
            gap_cnt <= gap_cnt + 24'h000001;
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   ack_source_a: assert property (
      $rose(s.cause[`LICT_BIT_ACK]) |->
         $past(ack_fire) ||
         $past(wr_force && bus.wdata[`LICT_BIT_ACK]))
      else $error("ack cause set without timer expiry");

   ack_wait_a: assert property (
      ack_frame_rx && (ack_delay != '0) |=> !ack_fire)
      else $error("ack cause fired before its delay");

   ecc_set_a: assert property (
      ecc_uncorrectable |=> s.cause[`LICT_BIT_ECC])
      else $error("ecc error did not set its cause");

   rsv_read_a: assert property (
      rd_cause |=> (rdata[`LICT_RSV_HI:`LICT_RSV_LO] == 8'h00) &&
                   (rdata[`LICT_BIT_ASSERTED] == $past(s.asserted)))
      else $error("cause read shows wrong upper bits");

   irq_gate_a: assert property (
      host_irq |-> s.asserted && pci_int_en)
      else $error("host interrupt without pending and enable");

   rise_cause_a: assert property (
      $rose(s.asserted) |-> $past(|(s.cause & s.mask)))
      else $error("pending rose without unmasked cause");

   free_fire_a: assert property (
      (|(s.cause & s.mask)) && !s.asserted && (s.pace == '0) &&
      !bus.rd && !bus.wr |=> s.asserted)
      else $error("unpaced interrupt not raised next cycle");

   timer_clr_a: assert property (
      ev_any |=> timers_clear)
      else $error("event did not clear delayed timers");

   rd_mask0_a: assert property (
      rd_cause && (s.mask == '0) && !ev_any |=> s.cause == '0)
      else $error("read with zero mask left cause set");

   rd_auto_a: assert property (
      rd_cause && (s.mask != '0) && s.asserted |=>
         (s.mask == ($past(s.mask) & ~$past(s.auto_mask))) &&
         (s.cause == $past(ev | frc)))
      else $error("pending read missed clear or auto mask");

   rd_plain_a: assert property (
      rd_cause && (s.mask != '0) && !s.asserted && !ev_any |=>
         (s.cause == $past(s.cause)) && (s.mask == $past(s.mask)))
      else $error("idle cause read changed state");

   wr_clear_a: assert property (
      wr_cause && !ev_any |=>
         (s.cause & $past(bus.wdata[`LICT_CAUSE_W-1:0])) == '0)
      else $error("write one did not clear cause bit");

   pend_hold_a: assert property (
      s.asserted |-> s.cause != '0)
      else $error("pending bit set with no cause");

   pace_gap_a: assert property (
      fire && seen_fire && (fire_pace != '0) |->
         gap_cnt >= ({8'h00, fire_pace} * 24'(`LICT_UNIT_CYCLES)))
      else $error("interrupts closer than pacing interval");

   pace_slow_a: assert property (
      fire && seen_fire && run_slow && (fire_pace != '0) |->
         gap_cnt >= ({8'h00, fire_pace} *
                     24'(`LICT_UNIT_CYCLES * `LICT_SLOW_FACTOR)))
      else $error("slow speed interrupts closer than four intervals");

   force_set_a: assert property (
      wr_force |=>
         (s.cause & $past(bus.wdata[`LICT_CAUSE_W-1:0] &
                          `LICT_CAUSE_WMASK)) ==
         $past(bus.wdata[`LICT_CAUSE_W-1:0] & `LICT_CAUSE_WMASK))
      else $error("force write did not set cause bits");

   force_rsv_a: assert property (
      wr_force && !(|ev) |=>
         (s.cause & ~`LICT_CAUSE_WMASK) ==
         ($past(s.cause) & ~`LICT_CAUSE_WMASK))
      else $error("force write touched a reserved bit");

   en_clear_a: assert property (
      wr_enclr |=> (s.mask & $past(bus.wdata[`LICT_CAUSE_W-1:0])) == '0)
      else $error("enable clear left mask bit set");

   pace_hold_a: assert property (
      (s.thr == LICT_THR_RUN) && (s.pace != '0) && !s.asserted |=>
         !s.asserted)
      else $error("interrupt raised inside pacing interval");

   pace_zero_a: assert property (
      (s.pace == '0) |=> (s.thr == LICT_THR_IDLE))
      else $error("pacing timer running with zero interval");

   timer_only_a: assert property (
      timers_clear |-> $past(ev_any))
      else $error("timers cleared without an event");

   pend_write_a: assert property (
      wr_cause && ((s.cause & ~bus.wdata[`LICT_CAUSE_W-1:0]) != '0) &&
      !fire |=> (s.asserted == $past(s.asserted)))
      else $error("cause write changed the pending bit");

   force_irq_a: assert property (
      (wr_force && (s.pace == '0) &&
       ((bus.wdata[`LICT_CAUSE_W-1:0] & s.mask) != '0))
      ##1 (!bus.rd && !bus.wr) |=> s.asserted)
      else $error("enabled force write raised no interrupt");

   pend_read_c: cover property (rd_cause && s.asserted);
   gap_check_c: cover property (fire && seen_fire && (fire_pace != '0));
   ack_fire_c: cover property (ack_fire);
   pace_run_c: cover property ((s.thr == LICT_THR_RUN) && tick);
   slow_fire_c: cover property (fire && slow_speed);

endmodule

// ---- testbench/lict_host_model.sv ----
// host cpu side of the interrupt line: counts asserts, measures spacing
// assumes host_irq is a level synchronous to mclk
`timescale 1ns/1ps

module lict_host_model (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic host_irq,
   output int        irq_count,
   output int        last_gap
);
   logic prev_irq;
   int   cyc;

   // gap is counted rise to rise, so a slow clear cannot hide a short gap
   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_irq  <= 1'b0;
         cyc       <= 0;
         irq_count <= 0;
         last_gap  <= 0;
      end else begin
         prev_irq <= host_irq;
         cyc      <= cyc + 1;
         if (host_irq && !prev_irq) begin
            irq_count <= irq_count + 1;
            last_gap  <= cyc;
            cyc       <= 1;
         end
      end
   end
endmodule

// ---- testbench/tb_top.sv ----
// register level tests of the interrupt cause and pacing block
// assumes lict_params.svh on the include path and a 200 MHz mclk
`timescale 1ns/1ps
`include "lict_params.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
   import lict_pkg::*;

   logic        mclk;
   logic        rst;
   lict_bus_s   bus;
   lict_data_t  rdata;
   lict_cause_t src_events;
   logic        ecc_unc;
   logic        ack_rx;
   lict_ack_t   ack_delay;
   logic        slow_speed;
   logic        pci_int_en;
   logic        host_irq;
   logic        timers_clear;
   int          irq_count;
   int          last_gap;
   int          failures;
   int          checks;

   lict_top dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
      .src_events(src_events), .ecc_uncorrectable(ecc_unc),
      .ack_frame_rx(ack_rx), .ack_delay(ack_delay),
      .slow_speed(slow_speed), .pci_int_en(pci_int_en),
      .host_irq(host_irq), .timers_clear(timers_clear));

   lict_host_model host (.mclk(mclk), .rst(rst), .host_irq(host_irq),
      .irq_count(irq_count), .last_gap(last_gap));

   always #2.5 mclk = ~mclk;

   task automatic wr(input logic [15:0] a, input lict_data_t d);
      @(posedge mclk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [15:0] a, input lict_data_t e);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask

   task automatic pulse(input lict_cause_t ev, input logic ecc,
                        input logic ack);
      @(posedge mclk);
      src_events <= ev;
      ecc_unc    <= ecc;
      ack_rx     <= ack;
      @(posedge mclk);
      src_events <= '0;
      ecc_unc    <= 1'b0;
      ack_rx     <= 1'b0;
      #1;
   endtask

   // bounded wait, a missing interrupt shows up as a mismatch
   task automatic wait_irq(input int lim);
      int i;
      i = 0;
      while (host_irq !== 1'b1 && i < lim) begin
         @(posedge mclk);
         #1;
         i++;
      end
      `CHK(host_irq, 1'b1)
   endtask

   // first interrupt starts pacing, second force must wait for it
   task automatic thr(input lict_data_t pace, input logic slow,
                      input int lo, input int hi);
      wr(`LICT_OFS_PACE, pace);
      rd(`LICT_OFS_PACE, pace);
      @(posedge mclk);
      slow_speed <= slow;
      wr(`LICT_OFS_FORCE, 32'h00000001);
      wait_irq(hi + 50);
      rd(`LICT_OFS_CAUSE, 32'h80000001);
      wr(`LICT_OFS_FORCE, 32'h00000001);
      wait_irq(hi + 50);
      @(posedge mclk);
      #1;
      `CHK(last_gap >= lo && last_gap <= hi, 1'b1)
      rd(`LICT_OFS_CAUSE, 32'h80000001);
      $display("pacing test interval %0d slow %0b done", pace, slow);
   endtask

   task automatic end_sim;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      end_sim();
   end

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      bus = '0;
      src_events = '0;
      ecc_unc = 1'b0;
      ack_rx = 1'b0;
      ack_delay = 8'h00;
      slow_speed = 1'b0;
      pci_int_en = 1'b1;
      failures = 0;
      checks = 0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(`LICT_OFS_PACE, 32'h00000000);
      rd(`LICT_OFS_ENSET, 32'h00000000);
      rd(`LICT_OFS_AUTOM, 32'h00000000);
      rd(`LICT_OFS_CAUSE, 32'h00000000);
      $display("reset test done");

      wr(`LICT_OFS_FORCE, 32'hFFFFFFFF);
      `CHK(timers_clear, 1'b1)
      rd(`LICT_OFS_CAUSE, 32'h0047D2F7);
      rd(`LICT_OFS_CAUSE, 32'h00000000);
      wr(`LICT_OFS_FORCE, 32'hFF800000);
      rd(`LICT_OFS_CAUSE, 32'h00000000);
      wr(16'h0100, 32'hFFFFFFFF);
      rd(16'h0100, 32'h00000000);
      $display("force test done");

      wr(`LICT_OFS_ENSET, 32'h00000001);
      pulse(23'h000001, 1'b0, 1'b0);
      `CHK(timers_clear, 1'b1)
      @(posedge mclk);
      #1;
      `CHK(host_irq, 1'b1)
      rd(`LICT_OFS_CAUSE, 32'h80000001);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(host_irq, 1'b0)
      @(posedge mclk);
      pci_int_en <= 1'b0;
      wr(`LICT_OFS_FORCE, 32'h00000001);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(host_irq, 1'b0)
      rd(`LICT_OFS_CAUSE, 32'h80000001);
      @(posedge mclk);
      pci_int_en <= 1'b1;
      $display("event test done");

      wr(`LICT_OFS_FORCE, 32'h00000002);
      rd(`LICT_OFS_CAUSE, 32'h00000002);
      rd(`LICT_OFS_CAUSE, 32'h00000002);
      wr(`LICT_OFS_CAUSE, 32'h80000000);
      rd(`LICT_OFS_CAUSE, 32'h00000002);
      wr(`LICT_OFS_CAUSE, 32'h00000002);
      rd(`LICT_OFS_CAUSE, 32'h00000000);
      $display("write clear test done");

      wr(`LICT_OFS_AUTOM, 32'h00000001);
      wr(`LICT_OFS_FORCE, 32'h00000001);
      wait_irq(20);
      rd(`LICT_OFS_CAUSE, 32'h80000001);
      rd(`LICT_OFS_ENSET, 32'h00000000);
      wr(`LICT_OFS_ENSET, 32'h00000003);
      wr(`LICT_OFS_ENCLR, 32'h00000001);
      rd(`LICT_OFS_ENSET, 32'h00000002);
      wr(`LICT_OFS_AUTOM, 32'h00000000);
      wr(`LICT_OFS_ENCLR, 32'hFFFFFFFF);
      rd(`LICT_OFS_ENSET, 32'h00000000);
      $display("auto mask test done");

      pulse(23'h7FFFFF, 1'b0, 1'b0);
      rd(`LICT_OFS_CAUSE, 32'h0005D2F7);
      pulse(23'h000000, 1'b1, 1'b0);
      rd(`LICT_OFS_CAUSE, 32'h00400000);
      @(posedge mclk);
      ack_delay <= 8'h01;
      pulse(23'h000000, 1'b0, 1'b1);
      rd(`LICT_OFS_CAUSE, 32'h00000000);
      repeat (120) @(posedge mclk);
      rd(`LICT_OFS_CAUSE, 32'h00020000);
      $display("ecc and ack test done");

      wr(`LICT_OFS_ENSET, 32'h00000001);
      thr(32'h00000000, 1'b0, 1, 16);
      thr(32'h00000002, 1'b0, 104, 116);
      thr(32'h00000002, 1'b1, 416, 428);
      thr(32'h00000041, 1'b0, 3380, 3392);
      `CHK(irq_count, 10)
      end_sim();
   end
endmodule
